// >>> core/fmo_map.svh
// Codes, constants, reset values and counts of the block.
// Assumes it is included by bare name after the package is compiled.
//
// What this block does
// RL1 - Reciprocal look-up: A operand, C result cycle four
// RL2 - Look-up leaves status, condition, zero alone
// RL3 - Real-to-integer gives 24-bit sign-extended integer
// RL4 - Real-to-integer spares status and zero registers
// RL5 - Integer-to-real from 24-bit, no status/zero update
// RL6 - Absolute value; denormal to zero, NaN to infinity
// RL7 - Source sets accumulate operand zero on monadics
// RL8 - Discard three results after a mode load
// RL9 - Mode load ignores cancel; keep off shadows
// RL10 - Status read goes out like a store
// RL11 - Status read/clear disable writes, pick I/O
// RL12 - Status clear zeroes all status bits
// RL13 - No-op is subtract r0 from r0, unwritten
// RL14 - Three 32-bit temporaries feed the accumulate input
// RL15 - Destination 00/01/10 pick temps three/two/one
// RL16 - Result always on C; temp loads cycle four
// RL17 - Write-disable bit set blocks general register write
// RL18 - Temporary copied in cycle two, readable next
// RL19 - Never read a temporary while it is written
// RL20 - Operand source codes pick C, B, temporaries
// RL21 - Multiplier second input: 0 B, 1 C
// RL22 - A, B, C buses 32 bits, one word each cycle
// RL23 - Source 110 gives two, 111 zero, 101 reserved
// RL24 - Function zero: second address picks misc op
`ifndef FMO_MAP_SVH
`define FMO_MAP_SVH

// Function field and misc selector codes
`define FMO_FUNC_MISC 3'h0
`define FMO_MISC_CLR 5'h00
`define FMO_MISC_STS 5'h01
`define FMO_MISC_MODE 5'h03
`define FMO_MISC_ABS 5'h04
`define FMO_MISC_FLT 5'h05
`define FMO_MISC_FIX 5'h06
`define FMO_MISC_LUT 5'h07

// Destination select codes
`define FMO_DST_T3 2'h0
`define FMO_DST_T2 2'h1
`define FMO_DST_T1 2'h2
`define FMO_DST_CBUS 2'h3

// Accumulate operand source codes
`define FMO_SRC_CBUS 3'h0
`define FMO_SRC_BBUS 3'h1
`define FMO_SRC_T2 3'h2
`define FMO_SRC_T1 3'h3
`define FMO_SRC_T3 3'h4
`define FMO_SRC_RSVD 3'h5
`define FMO_SRC_TWO 3'h6
`define FMO_SRC_ZERO 3'h7

// Single-precision constants
`define FMO_FP_TWO 32'h40000000
`define FMO_FP_ZERO 32'h00000000
`define FMO_FP_INF 32'h7f800000

// Reset values and counts
`define FMO_WORD_RST 32'h00000000
`define FMO_MODE_SETTLE_OPS 2'h3

`endif

// >>> core/fmo_pkg.sv
// Shared types.
// Assumes nothing of its surroundings.
package fmo_pkg;

  // One instruction word, as far as this block looks at it
  typedef struct packed {
    logic [2:0] func;
    logic [4:0] op_sel;
    logic [1:0] alu_destination_select;
    logic [2:0] accumulate_operand_source;
    logic mbin_sel;
    logic cwen_n;
    logic [1:0] condition_pin_update_field;
    logic [1:0] io_transfer_control;
  } fmo_instr_type;

  // Decoded operation class, one-hot
  typedef enum logic [7:0] {
    FMO_OP_ARITH = 8'h01,
    FMO_OP_CLR = 8'h02,
    FMO_OP_STS = 8'h04,
    FMO_OP_MODE = 8'h08,
    FMO_OP_ABS = 8'h10,
    FMO_OP_FLT = 8'h20,
    FMO_OP_FIX = 8'h40,
    FMO_OP_LUT = 8'h80
  } fmo_op_type;

  // One pipeline stage
  typedef struct packed {
    logic vld;
    logic cancel;
    fmo_op_type op;
    logic [1:0] alu_destination_select;
    logic cwen_n;
    logic [1:0] condition_pin_update_field;
    logic [31:0] a_opnd;
  } fmo_stage_type;

endpackage : fmo_pkg

// >>> core/fmo_monadic_unit.sv
// Combinational monadic functions.
// The caller registers the result.
`timescale 1ns/100ps
`include "fmo_map.svh"
module fmo_monadic_unit
  import fmo_pkg::*;
(
  // Operation and operand
  input wire fmo_op_type op_i,
  input wire logic [31:0] opnd_i,
  // Result
  output logic [31:0] result_o
);

  // Position of the highest set bit of a 24-bit magnitude
  function automatic logic [4:0] msb_pos(input logic [23:0] v);
    logic [4:0] p;
    p = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if (v[i]) p = 5'(i);
    end
    return p;
  endfunction : msb_pos

  logic sgn;
  logic [7:0] ex;
  logic [22:0] fr;
  logic [23:0] mag;
  logic [4:0] pos;
  logic [23:0] fixmag;

  assign sgn = opnd_i[31];
  assign ex = opnd_i[30:23];
  assign fr = opnd_i[22:0];

  // Integer magnitude for float; 24-bit input sign-extended
  assign mag = opnd_i[23] ? 24'(-opnd_i[23:0]) : opnd_i[23:0];
  assign pos = msb_pos(mag);
  // Truncating shift, small exponents only
  assign fixmag = {1'b1, fr} >> (5'h17 - 5'(ex - 8'h7f));

  always_comb begin
    result_o = `FMO_FP_ZERO;
    unique case (op_i)
      FMO_OP_ABS: begin // RL6
        if (ex == 8'hff && fr != 23'h000000) result_o = `FMO_FP_INF;
        else if (ex == 8'h00) result_o = `FMO_FP_ZERO;
        else result_o = {1'b0, opnd_i[30:0]};
      end
      FMO_OP_FLT: begin // RL5
        if (mag != 24'h000000)
          result_o = {opnd_i[23], 8'(8'h7f + {3'h0, pos}),
                      23'(mag << (5'h17 - pos))};
      end
      FMO_OP_FIX: begin // RL3
        // Out of range saturates to the 24-bit limits
        if (ex >= 8'h96)
          result_o = sgn ? 32'hff800000 : 32'h007fffff;
        else if (ex >= 8'h7f)
          result_o = sgn ? 32'(-{8'h00, fixmag}) : {8'h00, fixmag};
      end
      FMO_OP_LUT: begin // RL1
        // 1/(1+f) ~ (2-f)/2: exact at the ends, coarse in between
        if (ex == 8'h00) result_o = {sgn, 8'hff, 23'h000000};
        else if (ex >= 8'hfd) result_o = {sgn, 31'h00000000};
        else if (fr == 23'h000000) result_o = {sgn, 8'(8'hfe - ex), fr};
        else result_o = {sgn, 8'(8'hfd - ex), ~fr};
      end
      default: result_o = `FMO_FP_ZERO;
    endcase
  end

endmodule : fmo_monadic_unit

// >>> core/fmo_misc_top.sv
// Misc monadic operations, status/mode handling and the three
// temporary accumulator registers of the floating-point unit.
// Assumes the instruction word, cancel and A/B bus values arrive on
// CLK_SYS_I from logic in the same domain, and that the external ALU
// presents its arithmetic result during each operation's third cycle.
`timescale 1ns/100ps
`include "fmo_map.svh"
module fmo_misc_top
  import fmo_pkg::*;
#(
  parameter int STATUS_W = 8,
  parameter int MODE_W = 8
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // Instruction, first cycle of an operation
  input wire logic INSTR_VALID_I,
  input wire fmo_instr_type INSTR_I,
  input wire logic CANCEL_CURRENT_N_I,
  // Internal buses from the register file, first cycle
  input wire logic [31:0] A_BUS_I,
  input wire logic [31:0] B_BUS_I,
  // Arithmetic result and status events from the ALU
  input wire logic [31:0] ALU_RESULT_I,
  input wire logic [STATUS_W-1:0] STATUS_EVENT_I,
  // Result bus and operand ports, second and fourth cycles
  output logic [31:0] C_BUS_O,
  output logic [31:0] ABIN_O,
  output logic [31:0] MBIN_O,
  // Fourth-cycle write and update enables
  output logic REG_WRITE_O,
  output logic COND_UPDATE_O,
  output logic ZERO_UPDATE_O,
  output logic STATUS_UPDATE_O,
  // Status and store path
  output logic [STATUS_W-1:0] STATUS_O,
  output logic [31:0] X_STORE_DATA_O,
  output logic X_STORE_VALID_O,
  // Mode register
  output logic [MODE_W-1:0] MODE_O,
  output logic MODE_SETTLING_O
);

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Decode function and selector into an operation class
  function automatic fmo_op_type decode_op(input fmo_instr_type ins);
    fmo_op_type op;
    op = FMO_OP_ARITH;
    if (ins.func == `FMO_FUNC_MISC) begin // RL24
      unique case (ins.op_sel)
        `FMO_MISC_CLR: op = FMO_OP_CLR;
        `FMO_MISC_STS: op = FMO_OP_STS;
        `FMO_MISC_MODE: op = FMO_OP_MODE;
        `FMO_MISC_ABS: op = FMO_OP_ABS;
        `FMO_MISC_FLT: op = FMO_OP_FLT;
        `FMO_MISC_FIX: op = FMO_OP_FIX;
        `FMO_MISC_LUT: op = FMO_OP_LUT;
        // Reserved selectors run as plain ALU ops
        default: op = FMO_OP_ARITH;
      endcase
    end
    return op;
  endfunction : decode_op

  // True for ops that put a computed result on the C bus here
  function automatic logic is_monadic(input fmo_op_type op);
    return (op == FMO_OP_ABS) || (op == FMO_OP_FLT) ||
           (op == FMO_OP_FIX) || (op == FMO_OP_LUT);
  endfunction : is_monadic

  // True for ops that may touch the status and zero registers
  function automatic logic may_flag(input fmo_op_type op);
    return op == FMO_OP_ARITH;
  endfunction : may_flag

  // True for ops that may touch the condition register
  function automatic logic may_cond(input fmo_op_type op);
    return (op == FMO_OP_ARITH) || (op == FMO_OP_FIX) ||
           (op == FMO_OP_FLT);
  endfunction : may_cond

  ////////////////////////////////////////////////////////////////////
  // Declarations

  fmo_op_type op1;
  logic live1;
  fmo_stage_type p2;
  fmo_stage_type p3;
  fmo_stage_type p4;
  logic [31:0] treg [1:3];
  logic [31:0] next_abin;
  logic [31:0] mono_result;
  logic [STATUS_W-1:0] status;
  logic [MODE_W-1:0] mode;
  logic [1:0] settle_cnt;
  logic live4;
  logic treg_load;

  ////////////////////////////////////////////////////////////////////
  // First cycle decode

  // Decoded class of the instruction now on the input
  assign op1 = decode_op(INSTR_I);
  // Cancel drops the op; mode load is handled separately
  assign live1 = INSTR_VALID_I & CANCEL_CURRENT_N_I;

  ////////////////////////////////////////////////////////////////////
  // Pipeline stages two to four

  // Stage two: capture the op and its A operand
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      p2 <= '0;
      p2.op <= FMO_OP_ARITH;
    end else begin
      p2.vld <= INSTR_VALID_I;
      p2.cancel <= ~CANCEL_CURRENT_N_I;
      p2.op <= op1;
      p2.alu_destination_select <= INSTR_I.alu_destination_select;
      p2.cwen_n <= INSTR_I.cwen_n;
      p2.condition_pin_update_field <=
        INSTR_I.condition_pin_update_field;
      p2.a_opnd <= A_BUS_I; // RL22
    end
  end

  // Stage three: the op is in the ALU
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      p3 <= '0;
      p3.op <= FMO_OP_ARITH;
    end else begin
      p3 <= p2;
    end
  end

  // Stage four: the result stands on the C bus
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      p4 <= '0;
      p4.op <= FMO_OP_ARITH;
    end else begin
      p4 <= p3;
    end
  end

  // Fourth-cycle op that still has effect
  assign live4 = p4.vld & ~p4.cancel;

  ////////////////////////////////////////////////////////////////////
  // Monadic functions

  // Computed in cycle three from the captured A operand
  fmo_monadic_unit u_monadic (
    .op_i(p3.op),
    .opnd_i(p3.a_opnd),
    .result_o(mono_result)
  );

  ////////////////////////////////////////////////////////////////////
  // C bus

  // Every result reaches the C bus in the op's fourth cycle, even
  // when a temporary is the destination
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      C_BUS_O <= `FMO_WORD_RST;
    end else if (is_monadic(p3.op)) begin
      C_BUS_O <= mono_result; // RL1
    end else begin
      C_BUS_O <= ALU_RESULT_I; // RL16
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Temporary registers

  // Destination 11 leaves all temporaries alone
  assign treg_load = live4 &&
    (p4.alu_destination_select != `FMO_DST_CBUS);

  // Loaded in cycle four, same edge as the general register write
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      treg[1] <= `FMO_WORD_RST; // RL14
      treg[2] <= `FMO_WORD_RST;
      treg[3] <= `FMO_WORD_RST;
    end else if (treg_load) begin
      unique case (p4.alu_destination_select) // RL15
        `FMO_DST_T3: treg[3] <= C_BUS_O; // RL16
        `FMO_DST_T2: treg[2] <= C_BUS_O;
        `FMO_DST_T1: treg[1] <= C_BUS_O;
        default: treg[1] <= treg[1];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Accumulate and multiplier operand select

  // Source chosen in cycle one, held on the port through cycle two;
  // a temporary loading at this edge is forwarded to its reader
  always_comb begin
    next_abin = `FMO_FP_ZERO;
    unique case (INSTR_I.accumulate_operand_source) // RL20
      `FMO_SRC_CBUS: next_abin = C_BUS_O;
      `FMO_SRC_BBUS: next_abin = B_BUS_I;
      `FMO_SRC_T2: next_abin = treg[2]; // RL18
      `FMO_SRC_T1: next_abin = treg[1];
      `FMO_SRC_T3: next_abin = treg[3];
      `FMO_SRC_TWO: next_abin = `FMO_FP_TWO; // RL23
      `FMO_SRC_ZERO: next_abin = `FMO_FP_ZERO; // RL7
      // Reserved code reads as zero
      `FMO_SRC_RSVD: next_abin = `FMO_FP_ZERO; // RL23
    endcase
    if (treg_load && {p4.alu_destination_select,
        INSTR_I.accumulate_operand_source} inside {{`FMO_DST_T3,
        `FMO_SRC_T3}, {`FMO_DST_T2, `FMO_SRC_T2},
        {`FMO_DST_T1, `FMO_SRC_T1}}) begin
      next_abin = C_BUS_O; // RL18
    end
  end

  // Accumulate input, copied during the op's second cycle
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ABIN_O <= `FMO_WORD_RST;
    end else begin
      ABIN_O <= next_abin; // RL18
    end
  end

  // Multiplier second input
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      MBIN_O <= `FMO_WORD_RST;
    end else if (INSTR_I.mbin_sel) begin
      MBIN_O <= C_BUS_O; // RL21
    end else begin
      MBIN_O <= B_BUS_I; // RL21
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Fourth-cycle enables

  // General register write; a set write-disable bit always blocks it
  assign REG_WRITE_O = live4 & ~p4.cwen_n; // RL17

  // Condition update: look-up and absolute never touch it
  assign COND_UPDATE_O = live4 & may_cond(p4.op) &
    (p4.condition_pin_update_field != 2'h0); // RL2

  // Zero register: misc ops leave it alone
  assign ZERO_UPDATE_O = live4 & may_flag(p4.op); // RL4

  // Status register update from the ALU's events
  assign STATUS_UPDATE_O = live4 & may_flag(p4.op); // RL5

  ////////////////////////////////////////////////////////////////////
  // Status register

  // Sticky events; a clear op merges no events
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      status <= '0;
    end else if (live4 && p4.op == FMO_OP_CLR) begin
      status <= '0; // RL12
    end else if (STATUS_UPDATE_O) begin
      status <= status | STATUS_EVENT_I; // RL6
    end
  end

  assign STATUS_O = status;

  ////////////////////////////////////////////////////////////////////
  // Status readout over the store path

  // Latched in cycle one, shown in cycle two like a store;
  // register addresses play no part
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      X_STORE_DATA_O <= `FMO_WORD_RST;
    end else if (live1 && op1 == FMO_OP_STS) begin
      X_STORE_DATA_O <= 32'(status); // RL10
    end
  end

  // One-cycle mark that the readout word stands on the store path
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      X_STORE_VALID_O <= 1'b0;
    end else begin
      X_STORE_VALID_O <= live1 && op1 == FMO_OP_STS; // RL10
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode register

  // Loaded from the A bus in cycle one, cancelled or not, so
  // a load in a branch shadow still lands
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode <= '0;
    end else if (INSTR_VALID_I && op1 == FMO_OP_MODE) begin
      mode <= A_BUS_I[MODE_W-1:0]; // RL9
    end
  end

  assign MODE_O = mode;

  // Flags the next three ops for the source to drop;
  // advice only, nothing is suppressed
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      settle_cnt <= 2'h0;
    end else if (INSTR_VALID_I && op1 == FMO_OP_MODE) begin
      settle_cnt <= `FMO_MODE_SETTLE_OPS; // RL8
    end else if (INSTR_VALID_I && settle_cnt != 2'h0) begin
      settle_cnt <= settle_cnt - 2'h1;
    end
  end

  assign MODE_SETTLING_O = settle_cnt != 2'h0;

endmodule : fmo_misc_top

// >>> sim/fmo_misc_monitor.sv
// Checker of result timing, enables and temporaries.
// Bound to fmo_misc_top; sees only its ports.
`timescale 1ns/100ps
`include "fmo_map.svh"
module fmo_misc_monitor
  import fmo_pkg::*;
#(
  parameter int STATUS_W = 8,
  parameter int MODE_W = 8
) (
  // Clock, reset and instruction
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic INSTR_VALID_I,
  input wire fmo_instr_type INSTR_I,
  input wire logic CANCEL_CURRENT_N_I,
  // Buses
  input wire logic [31:0] A_BUS_I,
  input wire logic [31:0] B_BUS_I,
  input wire logic [31:0] C_BUS_O,
  input wire logic [31:0] ABIN_O,
  input wire logic [31:0] MBIN_O,
  // Enables, status and mode
  input wire logic REG_WRITE_O,
  input wire logic COND_UPDATE_O,
  input wire logic ZERO_UPDATE_O,
  input wire logic STATUS_UPDATE_O,
  input wire logic [STATUS_W-1:0] STATUS_O,
  input wire logic [31:0] X_STORE_DATA_O,
  input wire logic X_STORE_VALID_O,
  input wire logic [MODE_W-1:0] MODE_O,
  input wire logic MODE_SETTLING_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  // Live: taken and not cancelled
  wire logic misc = INSTR_VALID_I && INSTR_I.func == `FMO_FUNC_MISC;
  wire logic live = INSTR_VALID_I && CANCEL_CURRENT_N_I;
  wire logic [4:0] sel = INSTR_I.op_sel;
  wire logic [2:0] src = INSTR_I.accumulate_operand_source;

  // Magnitude, denormal to zero, NaN to infinity
  function automatic logic [31:0] abs_of(input logic [31:0] v);
    if (v[30:23] == 8'hff && v[22:0] != 23'h0) return `FMO_FP_INF;
    if (v[30:23] == 8'h00) return `FMO_FP_ZERO;
    return {1'b0, v[30:0]};
  endfunction : abs_of

  // B bus and constant sources; reserved reads zero
  function automatic logic [31:0] src_val(input logic [2:0] s,
      input logic [31:0] b);
    if (s == `FMO_SRC_BBUS) return b;
    if (s == `FMO_SRC_TWO) return `FMO_FP_TWO;
    return `FMO_FP_ZERO;
  endfunction : src_val

  // Source code reading back a destination's temporary
  function automatic logic [2:0] tsrc(input logic [1:0] d);
    if (d == `FMO_DST_T3) return `FMO_SRC_T3;
    if (d == `FMO_DST_T2) return `FMO_SRC_T2;
    return `FMO_SRC_T1;
  endfunction : tsrc

  //////////////////////////////////////////////////////////////////////
  property p_sts_read;
    live && misc && sel == `FMO_MISC_STS |=>
      X_STORE_VALID_O && X_STORE_DATA_O == 32'($past(STATUS_O));
  endproperty
  a_sts_read: assert property (p_sts_read)
    else $error("status readout wrong");
  property p_clear;
    live && misc && sel == `FMO_MISC_CLR |-> ##4 STATUS_O == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("status not cleared");
  property p_quiet;
    misc && sel inside {`FMO_MISC_LUT, `FMO_MISC_ABS} |-> ##3
      !(COND_UPDATE_O || ZERO_UPDATE_O || STATUS_UPDATE_O);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("flag update on quiet op");
  property p_conv;
    misc && sel inside {`FMO_MISC_FIX, `FMO_MISC_FLT} |-> ##3
      !ZERO_UPDATE_O && !STATUS_UPDATE_O;
  endproperty
  a_conv: assert property (p_conv)
    else $error("conversion updated status");
  property p_abs;
    misc && sel == `FMO_MISC_ABS |-> ##3
      C_BUS_O == abs_of($past(A_BUS_I, 3));
  endproperty
  a_abs: assert property (p_abs)
    else $error("absolute value wrong");
  property p_regwr;
    INSTR_VALID_I |-> ##3 REG_WRITE_O ==
      ($past(CANCEL_CURRENT_N_I, 3) && !$past(INSTR_I.cwen_n, 3));
  endproperty
  a_regwr: assert property (p_regwr)
    else $error("register write enable wrong");
  // Writer to a reader four cycles on
  property p_treg;
    live && !misc && INSTR_I.alu_destination_select != `FMO_DST_CBUS
      ##4 INSTR_VALID_I
      && src == tsrc($past(INSTR_I.alu_destination_select, 4))
      |=> ABIN_O == $past(C_BUS_O, 2);
  endproperty
  a_treg: assert property (p_treg)
    else $error("temporary readback wrong");
  property p_src;
    INSTR_VALID_I && src inside {`FMO_SRC_BBUS, `FMO_SRC_RSVD,
      `FMO_SRC_TWO, `FMO_SRC_ZERO} |=>
      ABIN_O == src_val($past(src), $past(B_BUS_I));
  endproperty
  a_src: assert property (p_src)
    else $error("accumulate operand wrong");
  property p_mbin;
    INSTR_VALID_I && !INSTR_I.mbin_sel |=> MBIN_O == $past(B_BUS_I);
  endproperty
  a_mbin: assert property (p_mbin)
    else $error("multiplier input wrong");
  property p_mode;
    misc && sel == `FMO_MISC_MODE |=> MODE_SETTLING_O &&
      MODE_O == MODE_W'($past(A_BUS_I));
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode load wrong");
endmodule : fmo_misc_monitor

bind fmo_misc_top fmo_misc_monitor #(
  .STATUS_W(STATUS_W), .MODE_W(MODE_W)
) u_fmo_misc_monitor (.*);

// >>> sim/fmo_seq_model.sv
// Instruction source model.
// Requests come from the bench after a rising edge.
`timescale 1ns/100ps
`include "fmo_map.svh"
module fmo_seq_model
  import fmo_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Requests from the bench
  input wire logic req_valid_i,
  input wire fmo_instr_type req_instr_i,
  input wire logic [31:0] req_a_i,
  input wire logic [31:0] req_b_i,
  input wire logic req_cancel_n_i,
  // Instruction and register-file side
  output logic instr_valid_o,
  output fmo_instr_type instr_o,
  output logic cancel_n_o,
  output logic [31:0] a_bus_o,
  output logic [31:0] b_bus_o
);
  logic [31:0] last_a;
  logic [31:0] last_b;
  logic is_misc;

  // Idle buses toggle: stale operands never pass for data
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {last_a, last_b} <= 64'h0;
    end else begin
      {last_a, last_b} <= {a_bus_o, b_bus_o};
    end
  end

  // Fields the source owns on monadic and status operations
  always_comb begin
    instr_o = req_instr_i;
    is_misc = req_instr_i.func == `FMO_FUNC_MISC;
    if (is_misc && req_instr_i.op_sel inside {`FMO_MISC_ABS,
        `FMO_MISC_FLT, `FMO_MISC_FIX, `FMO_MISC_LUT}) begin
      instr_o.accumulate_operand_source = `FMO_SRC_ZERO;
    end
    if (is_misc && req_instr_i.op_sel[4:1] == 4'h0) begin
      instr_o.cwen_n = 1'b1;
      instr_o.condition_pin_update_field = 2'h0;
      instr_o.io_transfer_control = {req_instr_i.op_sel[0], 1'b0};
    end
  end

  // Buses carry operands only in an instruction's first cycle
  assign instr_valid_o = req_valid_i;
  assign cancel_n_o = req_valid_i ? req_cancel_n_i : 1'b1;
  assign a_bus_o = req_valid_i ? req_a_i : ~last_a;
  assign b_bus_o = req_valid_i ? req_b_i : ~last_b;
endmodule : fmo_seq_model

// >>> sim/test_fpu_misc_ops_and_temp_regs.sv
// Bench of the misc-op block.
// The checker binds itself.
`timescale 1ns/100ps
`include "fmo_map.svh"
module test_fpu_misc_ops_and_temp_regs
  import fmo_pkg::*;
;
  logic CLK_SYS_I = 1'b0;
  logic RSTN_I = 1'b0;
  logic req_valid = 1'b0;
  fmo_instr_type req_instr = '0;
  logic [31:0] req_a = 32'h0;
  logic [31:0] req_b = 32'h0;
  logic req_cn = 1'b1;
  logic [31:0] ALU_RESULT_I = 32'h0;
  logic [7:0] STATUS_EVENT_I = 8'h0;
  logic INSTR_VALID_I, CANCEL_CURRENT_N_I, X_STORE_VALID_O;
  fmo_instr_type INSTR_I;
  logic [31:0] A_BUS_I, B_BUS_I, C_BUS_O, ABIN_O, MBIN_O, X_STORE_DATA_O;
  logic REG_WRITE_O, COND_UPDATE_O, ZERO_UPDATE_O, STATUS_UPDATE_O;
  logic MODE_SETTLING_O;
  logic [7:0] STATUS_O, MODE_O;
  logic [31:0] abin_s, mbin_s, xd_s, c_s;
  logic xv_s, rw_s, cu_s, zu_s, su_s;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // Monadic cases: selector, operand, expected result
  localparam logic [4:0] MS [9] = '{5'h04, 5'h04, 5'h04, 5'h06, 5'h06,
    5'h05, 5'h05, 5'h07, 5'h07};
  localparam logic [31:0] MA [9] = '{32'hbf800000, 32'h80000001,
    32'hffc00000, 32'h3fc00000, 32'hc0400000, 32'h00000003,
    32'hfffffffe, 32'h40000000, 32'hc0000000};
  localparam logic [31:0] ME [9] = '{32'h3f800000, 32'h0, 32'h7f800000,
    32'h1, 32'hfffffffd, 32'h40400000, 32'hc0000000, 32'h3f000000,
    32'hbf000000};
  localparam logic [2:0] TS [3] = '{3'h4, 3'h2, 3'h3};
  localparam logic [2:0] SC [4] = '{3'h1, 3'h5, 3'h6, 3'h7};
  localparam logic [31:0] SE [4] = '{32'h5a5a1234, 32'h0, 32'h40000000,
    32'h0};

  // 100 MHz clock
  initial begin
    forever #5 CLK_SYS_I = ~CLK_SYS_I;
  end

  // Hang guard
  always @(posedge CLK_SYS_I) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  fmo_seq_model u_fmo_seq_model (
    .clk_i(CLK_SYS_I), .rstn_i(RSTN_I), .req_valid_i(req_valid),
    .req_instr_i(req_instr), .req_a_i(req_a), .req_b_i(req_b),
    .req_cancel_n_i(req_cn), .instr_valid_o(INSTR_VALID_I),
    .instr_o(INSTR_I), .cancel_n_o(CANCEL_CURRENT_N_I),
    .a_bus_o(A_BUS_I), .b_bus_o(B_BUS_I)
  );
  fmo_misc_top u_fmo_misc_top (.*);

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic fmo_instr_type mk(input logic [2:0] f,
      input logic [4:0] s, input logic [1:0] d, input logic [2:0] src,
      input logic cw);
    fmo_instr_type i;
    i = '0;
    i.func = f;
    i.op_sel = s;
    i.alu_destination_select = d;
    i.accumulate_operand_source = src;
    i.cwen_n = cw;
    i.condition_pin_update_field = 2'h1;
    return i;
  endfunction : mk

  // One op; samples cycles two and four
  task automatic run(input fmo_instr_type i, input logic [31:0] a,
      input logic [31:0] b, input logic cn, input logic [7:0] ev);
    @(posedge CLK_SYS_I);
    req_valid <= 1'b1;
    req_instr <= i;
    req_a <= a;
    req_b <= b;
    req_cn <= cn;
    ALU_RESULT_I <= ~a;
    STATUS_EVENT_I <= 8'h0;
    @(posedge CLK_SYS_I);
    req_valid <= 1'b0;
    #1;
    {abin_s, mbin_s, xd_s, xv_s} = {ABIN_O, MBIN_O, X_STORE_DATA_O,
      X_STORE_VALID_O};
    repeat (2) @(posedge CLK_SYS_I);
    STATUS_EVENT_I <= ev;
    #1;
    {c_s, rw_s, cu_s, zu_s, su_s} = {C_BUS_O, REG_WRITE_O, COND_UPDATE_O,
      ZERO_UPDATE_O, STATUS_UPDATE_O};
  endtask : run

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    fmo_instr_type nop;
    logic [31:0] ta [3];
    int k;
    nop = mk(3'h2, 5'h0, 2'h3, 3'h1, 1'b1);
    nop.condition_pin_update_field = 2'h0;
    repeat (2) @(posedge CLK_SYS_I);
    RSTN_I <= 1'b1;
    // Monadics, write and flags armed
    for (k = 0; k < 9; k++) begin
      run(mk(3'h0, MS[k], 2'h3, 3'h1, 1'b0), MA[k], 32'h0, 1'b1, 8'h0);
      chk(c_s, ME[k]);
      chk(rw_s, 1'b1);
      chk({zu_s, su_s}, 2'h0);
      chk(abin_s, 32'h0);
      if (k < 3 || k > 6) chk(cu_s, 1'b0);
    end
    $display("monadic test done");
    // Writes spaced apart from their reads
    for (k = 0; k < 3; k++) begin
      ta[k] = 32'h00ff0f00 + k;
      run(mk(3'h3, 5'h0, 2'(k), 3'h1, 1'b1), ta[k], 32'h0, 1'b1, 8'h0);
      chk(c_s, ~ta[k]);
      chk(rw_s, 1'b0);
    end
    // Readers write the C bus only
    for (k = 2; k >= 0; k--) begin
      run(mk(3'h3, 5'h0, 2'h3, TS[k], 1'b1), 32'h0, 32'h0, 1'b1, 8'h0);
      chk(abin_s, ~ta[k]);
    end
    $display("temporary register test done");
    for (k = 0; k < 4; k++) begin
      run(mk(3'h3, 5'h0, 2'h3, SC[k], 1'b1), 32'h0, SE[0], 1'b1, 8'h0);
      chk(abin_s, SE[k]);
      chk(mbin_s, SE[0]);
    end
    $display("operand source test done");
    // Status set, read, cancelled clear, clear
    run(mk(3'h3, 5'h0, 2'h3, 3'h1, 1'b0), 32'h1, 32'h0, 1'b1, 8'h5a);
    run(mk(3'h0, 5'h01, 2'h3, 3'h1, 1'b0), 32'h0, 32'h0, 1'b1, 8'h0);
    chk(xv_s, 1'b1);
    chk(xd_s, 32'h5a);
    for (k = 0; k < 2; k++) begin
      run(mk(3'h0, 5'h00, 2'h3, 3'h1, 1'b0), 32'h0, 32'h0, k[0], 8'h0);
      @(posedge CLK_SYS_I);
      #1;
      chk(STATUS_O, k ? 8'h00 : 8'h5a);
    end
    $display("status test done");
    // Cancelled mode load, three no-ops
    run(mk(3'h0, 5'h03, 2'h3, 3'h1, 1'b1), 32'hc3, 32'h0, 1'b0, 8'h0);
    chk(MODE_O, 8'hc3);
    for (k = 0; k < 3; k++) begin
      chk(MODE_SETTLING_O, 1'b1);
      run(nop, 32'h0, 32'h0, 1'b1, 8'h0);
      chk(rw_s | cu_s, 1'b0);
    end
    chk(MODE_SETTLING_O, 1'b0);
    $display("mode test done");
    end_of_test();
  end
endmodule : test_fpu_misc_ops_and_temp_regs
